// ===== core/calib_pkg.sv
package calib_pkg;

   // ==========================================================
   // word layout
   localparam int WORD_W        = 16;
   localparam int DATA_W        = 11;
   localparam int PAR_W         = 4;
   localparam int ECC_MSB       = 15;
   localparam int ECC_LSB       = 12;
   localparam int DED_BIT       = 11;
   localparam int RSV_MSB       = 10;
   localparam int RSV_LSB       = 7;
   localparam int TRIM_MSB      = 6;
   localparam int TRIM_W        = 7;
   localparam int OFF_W         = 8;
   localparam int FSM_DIS_BIT   = 10;
   localparam int BIST_DIS_BIT  = 9;
   localparam int SHORT_OFF_BIT = 8;
   localparam int POL_BIT       = 7;

   // ==========================================================
   // storage words: two in the nonvolatile store, two shadows
   localparam int NWORDS     = 4;
   localparam int NV_WORDS   = 2;
   localparam int W_NV_GAIN  = 0;
   localparam int W_NV_DIAG  = 1;
   localparam int W_SH_GAIN  = 2;
   localparam int W_SH_DIAG  = 3;

   // ==========================================================
   // register indices, byte address is four times the index
   localparam int             IDX_W       = 8;
   localparam logic [IDX_W-1:0] IDX_NV_GAIN = 8'h03;
   localparam logic [IDX_W-1:0] IDX_NV_DIAG = 8'h04;
   localparam logic [IDX_W-1:0] IDX_SH_GAIN = 8'h43;
   localparam logic [IDX_W-1:0] IDX_SH_DIAG = 8'h44;
   localparam logic [IDX_W-1:0] IDX_STATUS  = 8'h60;
   localparam logic [IDX_W-1:0] IDX_MASK    = 8'h61;
   localparam logic [IDX_W-1:0] IDX_CTRL    = 8'h62;
   localparam logic [IDX_W-1:0] IDX_FLIP    = 8'h63;

   // ==========================================================
   // status, control and fault-injection fields
   localparam int ST_W          = 3;
   localparam int ST_FSM        = 0;
   localparam int ST_SEC        = 1;
   localparam int ST_DED        = 2;
   localparam int CTRL_LOAD_BIT = 0;
   localparam int FLIP_SEL_LSB  = 16;
   localparam int FLIP_SEL_W    = 2;

   localparam logic [WORD_W-1:0] RESET_WORD = 16'h0000;
   localparam logic [WORD_W-1:0] ZERO_HI    = 16'h0000;
   localparam logic [DATA_W-1:0] ALL_WR     = 11'h7ff;
   localparam logic [DATA_W-1:0] SH_GAIN_WR = 11'h07f;

   // ==========================================================
   // hamming position of data bit k (powers of two hold parity)
   function automatic logic [PAR_W-1:0] ham_pos(input int k);
      int n;
      int j;
      logic [PAR_W-1:0] r;
      r = '0;
      j = 0;
      for (n = 3; n < 16; n++) begin
         if ((n & (n - 1)) != 0) begin
            if (j == k) r = PAR_W'(n);
            j++;
         end
      end
      return r;
   endfunction

   function automatic logic [PAR_W-1:0] ham_par(input logic [DATA_W-1:0] d);
      logic [PAR_W-1:0] p;
      p = '0;
      for (int k = 0; k < DATA_W; k++) begin
         if (d[k]) p = p ^ ham_pos(k);
      end
      return p;
   endfunction

endpackage

// ===== core/ecc_encode.sv
`timescale 1ns/10ps
module ecc_encode
   import calib_pkg::*;
(
   input  wire logic [DATA_W-1:0] data_i,
   output logic      [WORD_W-1:0] word_o
);

   wire logic [PAR_W-1:0] par;

   assign par    = ham_par(data_i);
   // overall bit makes the whole word even so a second flip is seen
   assign word_o = {par, ^{par, data_i}, data_i};

endmodule

// ===== core/ecc_decode.sv
`timescale 1ns/10ps
module ecc_decode
   import calib_pkg::*;
(
   input  wire logic [WORD_W-1:0] word_i,
   output logic      [DATA_W-1:0] data_o,
   output logic                   sec_o,
   output logic                   ded_o
);

   wire logic [PAR_W-1:0] syn;
   wire logic             odd;

   assign syn = ham_par(word_i[DATA_W-1:0]) ^ word_i[ECC_MSB:ECC_LSB];
   assign odd = ^word_i;

   genvar k;
   generate
      for (k = 0; k < DATA_W; k++) begin : g_fix
         assign data_o[k] = word_i[k] ^ (odd && (syn == ham_pos(k)));
      end
   endgenerate

   // odd weight is one flip (possibly in a check bit), even with syndrome is two
   assign sec_o = odd;
   assign ded_o = !odd && (syn != '0);

endmodule

// ===== core/calib_regs.sv
`timescale 1ns/10ps
// Functional notes
// - bits 15:12 hold the parity nibble
// - bit 11 holds the double-error parity
// - 7-bit gain code, 0.125 percent per step
// - diag bit 10 low enables fsm error interrupt
// - diag bit 9 low enables startup self test
// - diag bit 8 low lets short fault alarm
// - diag bit 7 selects add or subtract offset
// - 7-bit offset code, 0.0015 percent per step
// - fsm error disable read/write, resets zero
module calib_regs
   import calib_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic [IDX_W+1:0]  adr_i,
   input  wire logic [31:0]       dat_i,
   output logic      [31:0]       dat_o,
   input  wire logic              we_i,
   input  wire logic [3:0]        sel_i,
   input  wire logic              cyc_i,
   input  wire logic              stb_i,
   output logic                   ack_o,
   input  wire logic              fsm_err_i,
   input  wire logic              rx_short_i,
   output logic                   irq_o,
   output logic      [TRIM_W-1:0] rx1_amplitude_trim_o,
   output logic      [OFF_W-1:0]  rx1_offset_trim_o,
   output logic                   bist_enable_o,
   output logic                   diag_entry_o
);

   // ==========================================================
   // decode helpers
   function automatic logic [NWORDS-1:0] word_hit(input logic [IDX_W-1:0] i);
      word_hit = {i == IDX_SH_DIAG, i == IDX_SH_GAIN,
                  i == IDX_NV_DIAG, i == IDX_NV_GAIN};
   endfunction

   function automatic logic [DATA_W-1:0] wr_mask(input int g);
      wr_mask = (g == W_SH_GAIN) ? SH_GAIN_WR : ALL_WR;
   endfunction

   // ==========================================================
   // bus decode
   logic [WORD_W-1:0]             store [NWORDS];
   logic [NWORDS-1:0][DATA_W-1:0] cor;
   logic [NWORDS-1:0][DATA_W-1:0] merged;
   logic [NWORDS-1:0][DATA_W-1:0] next_data;
   logic [NWORDS-1:0][WORD_W-1:0] enc;
   logic [NWORDS-1:0][WORD_W-1:0] rd_word;
   logic [NWORDS-1:0]             sec;
   logic [NWORDS-1:0]             ded;
   logic [NWORDS-1:0]             upd;
   logic [ST_W-1:0]               st;
   logic [ST_W-1:0]               msk;

   wire logic [IDX_W-1:0]      idx;
   wire logic                  req;
   wire logic                  wr;
   wire logic [NWORDS-1:0]     sel_w;
   wire logic [NWORDS-1:0]     hit;
   wire logic [DATA_W-1:0]     bm;
   wire logic                  load;
   wire logic                  flip;
   wire logic [FLIP_SEL_W-1:0] fsel;
   wire logic [WORD_W-1:0]     word_val;
   wire logic [31:0]           rdata;

   assign idx   = adr_i[IDX_W+1:2];
   // ack drops for one cycle after each answer, so req is one cycle wide
   assign req   = cyc_i && stb_i && !ack_o;
   assign wr    = req && we_i;
   assign sel_w = word_hit(idx);
   assign hit   = sel_w & {NWORDS{wr}};
   assign bm    = {{(DATA_W - 8){sel_i[1]}}, {8{sel_i[0]}}};
   assign load  = wr && (idx == IDX_CTRL) && sel_i[0] && dat_i[CTRL_LOAD_BIT];
   assign flip  = wr && (idx == IDX_FLIP);
   assign fsel  = dat_i[FLIP_SEL_LSB +: FLIP_SEL_W];

   // ==========================================================
   // protected storage words
   genvar g;
   generate
      for (g = 0; g < NWORDS; g++) begin : g_word
         ecc_decode u_dec (
            .word_i (store[g]),
            .data_o (cor[g]),
            .sec_o  (sec[g]),
            .ded_o  (ded[g])
         );

         // byte lanes merge into the corrected value, so a write scrubs the word
         assign merged[g] = (cor[g] & ~(bm & wr_mask(g)))
                          | (dat_i[DATA_W-1:0] & bm & wr_mask(g));

         // shadow load copies the corrected store word; reserved gain bits drop
         assign next_data[g] = ((load && g >= NV_WORDS) ? cor[g % NV_WORDS]
                                                        : merged[g]) & wr_mask(g);
         assign upd[g] = hit[g] || (load && g >= NV_WORDS);

         ecc_encode u_enc (
            .data_i (next_data[g]),
            .word_o (enc[g])
         );

         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               store[g] <= RESET_WORD;
            end else if (upd[g]) begin
               store[g] <= enc[g];
            end else if (flip && fsel == FLIP_SEL_W'(g)) begin
               store[g] <= store[g] ^ dat_i[WORD_W-1:0];
            end
         end

         // check bits read back raw, data bits read back corrected
         // shadow reserved gain bits read zero even after an uncorrectable fault
         assign rd_word[g] = sel_w[g] ? {store[g][ECC_MSB:DED_BIT], cor[g] & wr_mask(g)}
                                      : RESET_WORD;
      end
   endgenerate

   // ==========================================================
   // read selection
   assign word_val = rd_word[W_NV_GAIN] | rd_word[W_NV_DIAG]
                   | rd_word[W_SH_GAIN] | rd_word[W_SH_DIAG];

   assign rdata = (|sel_w)             ? {ZERO_HI, word_val}
                : (idx == IDX_STATUS)  ? {{(32 - ST_W){1'b0}}, st}
                : (idx == IDX_MASK)    ? {{(32 - ST_W){1'b0}}, msk}
                :                        {ZERO_HI, RESET_WORD};

   // ==========================================================
   // wishbone answer: one wait cycle, unmapped reads return zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= {ZERO_HI, RESET_WORD};
      end else begin
         ack_o <= req;
         if (req) dat_o <= rdata;
      end
   end

   // ==========================================================
   // sticky events and interrupt
   wire logic [ST_W-1:0] ev;
   wire logic [ST_W-1:0] st_w1c;
   wire logic [ST_W-1:0] next_st;

   assign ev[ST_FSM] = fsm_err_i && !cor[W_SH_DIAG][FSM_DIS_BIT];
   assign ev[ST_SEC] = |sec;
   assign ev[ST_DED] = |ded;
   assign st_w1c  = (wr && idx == IDX_STATUS && sel_i[0]) ? dat_i[ST_W-1:0] : '0;
   // an event in the clearing cycle survives
   assign next_st = (st & ~st_w1c) | ev;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st    <= '0;
         msk   <= '0;
         irq_o <= 1'b0;
      end else begin
         st    <= next_st;
         if (wr && idx == IDX_MASK && sel_i[0]) msk <= dat_i[ST_W-1:0];
         irq_o <= |(st & msk);
      end
   end

   // ==========================================================
   // trims and diagnostic controls from the shadow bank
   wire logic [OFF_W-1:0] off_mag;
   wire logic [OFF_W-1:0] next_offset;

   assign off_mag     = {1'b0, cor[W_SH_DIAG][TRIM_MSB:0]};
   // signed offset steps; the analogue side scales one step to 0.0015 percent
   assign next_offset = cor[W_SH_DIAG][POL_BIT] ? -off_mag : off_mag;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx1_amplitude_trim_o <= '0;
         rx1_offset_trim_o    <= '0;
         bist_enable_o        <= 1'b0;
         diag_entry_o         <= 1'b0;
      end else begin
         rx1_amplitude_trim_o <= cor[W_SH_GAIN][TRIM_MSB:0];
         rx1_offset_trim_o    <= next_offset;
         bist_enable_o        <= !cor[W_SH_DIAG][BIST_DIS_BIT];
         diag_entry_o         <= rx_short_i && !cor[W_SH_DIAG][SHORT_OFF_BIT];
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   ecc_nibble_a: assert property (
      hit[W_NV_GAIN] |=> store[W_NV_GAIN][ECC_MSB:ECC_LSB]
                         == ham_par(store[W_NV_GAIN][DATA_W-1:0]))
      else $error("parity nibble wrong after write");

   ded_parity_a: assert property (
      hit[W_NV_DIAG] |=> !(^store[W_NV_DIAG]) && !sec[W_NV_DIAG])
      else $error("double-error bit wrong after write");

   gain_reserved_a: assert property (
      (hit[W_SH_GAIN] || load) |=> store[W_SH_GAIN][RSV_MSB:RSV_LSB] == '0)
      else $error("reserved gain bits written");

   gain_code_a: assert property (
      hit[W_SH_GAIN] && sel_i[0]
      |-> ##2 rx1_amplitude_trim_o == $past(dat_i[TRIM_MSB:0], 2))
      else $error("gain trim not applied");

   fsm_irq_a: assert property (
      fsm_err_i && !cor[W_SH_DIAG][FSM_DIS_BIT] && msk[ST_FSM]
      |=> st[ST_FSM] ##1 irq_o)
      else $error("fsm error not signalled");

   bist_ctrl_a: assert property (
      hit[W_SH_DIAG] && sel_i[1] |-> ##2 bist_enable_o == !$past(dat_i[BIST_DIS_BIT], 2))
      else $error("self test enable wrong");

   short_alarm_a: assert property (
      rx_short_i && cor[W_SH_DIAG][SHORT_OFF_BIT] |=> !diag_entry_o)
      else $error("short alarm not suppressed");

   offset_sub_a: assert property (
      hit[W_SH_DIAG] && sel_i[0] && dat_i[POL_BIT] && dat_i[TRIM_MSB:0] != '0
      |-> ##2 rx1_offset_trim_o[OFF_W-1])
      else $error("offset not subtracted");

   offset_add_a: assert property (
      hit[W_SH_DIAG] && sel_i[0] && !dat_i[POL_BIT]
      |-> ##2 rx1_offset_trim_o == {1'b0, $past(dat_i[TRIM_MSB:0], 2)})
      else $error("offset magnitude wrong");

   fsm_dis_rw_a: assert property (
      hit[W_NV_DIAG] && sel_i[1] |=> cor[W_NV_DIAG][FSM_DIS_BIT] == $past(dat_i[FSM_DIS_BIT]))
      else $error("fsm disable bit not stored");

   single_fix_a: assert property (
      flip && $onehot(dat_i[WORD_W-1:0]) && !sec[fsel] && !ded[fsel]
      |=> sec[$past(fsel)] && cor == $past(cor) ##1 st[ST_SEC])
      else $error("single error not corrected");

   double_flag_a: assert property (
      flip && $countones(dat_i[WORD_W-1:0]) == 2 && !sec[fsel] && !ded[fsel]
      |=> ded[$past(fsel)] ##1 st[ST_DED])
      else $error("double error not flagged");

   // ==========================================================
   // bus answer, read-back, interrupt, diagnostic control and shadow load checks
   // ack_o is registered, so the bus answer and read-back checks look one edge back at the request
   ack_answer_a: assert property (
      req |=> ack_o)
      else $error("request not answered");

   ack_pulse_a: assert property (
      ack_o |=> !ack_o)
      else $error("ack longer than one cycle");

   ack_cause_a: assert property (
      ack_o |-> $past(cyc_i) && $past(stb_i))
      else $error("ack without request");

   rsv_read_a: assert property (
      ack_o && !$past(we_i) && $past(idx) == IDX_SH_GAIN |-> dat_o[RSV_MSB:RSV_LSB] == '0)
      else $error("reserved gain bits read nonzero");

   check_read_a: assert property (
      ack_o && !$past(we_i) && $past(idx) == IDX_NV_DIAG
      |-> dat_o[ECC_MSB:DED_BIT] == $past(store[W_NV_DIAG][ECC_MSB:DED_BIT]))
      else $error("check bits not read back");

   status_set_a: assert property (
      ev != '0 |=> (st & $past(ev)) == $past(ev))
      else $error("event lost in status");

   irq_on_a: assert property (
      (st & msk) != '0 |=> irq_o)
      else $error("interrupt missing");

   irq_off_a: assert property (
      (st & msk) == '0 |=> !irq_o)
      else $error("interrupt without cause");

   fsm_masked_a: assert property (
      fsm_err_i && cor[W_SH_DIAG][FSM_DIS_BIT] && !st[ST_FSM] |=> !st[ST_FSM])
      else $error("disabled fsm error signalled");

   bist_off_a: assert property (
      cor[W_SH_DIAG][BIST_DIS_BIT] |=> !bist_enable_o)
      else $error("self test not skipped");

   short_on_a: assert property (
      rx_short_i && !cor[W_SH_DIAG][SHORT_OFF_BIT] |=> diag_entry_o)
      else $error("short fault did not enter diagnostic state");

   diag_idle_a: assert property (
      !rx_short_i |=> !diag_entry_o)
      else $error("diagnostic state without short fault");

   offset_zero_a: assert property (
      cor[W_SH_DIAG][TRIM_MSB:0] == '0 |=> rx1_offset_trim_o == '0)
      else $error("zero offset code applied a correction");

   gain_zero_a: assert property (
      cor[W_SH_GAIN][TRIM_MSB:0] == '0 |=> rx1_amplitude_trim_o == '0)
      else $error("zero gain code applied a correction");

   fsm_dis_sh_a: assert property (
      hit[W_SH_DIAG] && sel_i[1] |=> cor[W_SH_DIAG][FSM_DIS_BIT] == $past(dat_i[FSM_DIS_BIT]))
      else $error("shadow fsm disable bit not stored");

   shadow_load_a: assert property (
      load |=> cor[W_SH_DIAG] == $past(cor[W_NV_DIAG])
               && cor[W_SH_GAIN] == ($past(cor[W_NV_GAIN]) & SH_GAIN_WR))
      else $error("shadow load did not copy the store");

   // every word, after any update, carries a consistent check field
   genvar h;
   generate
      for (h = 0; h < NWORDS; h++) begin : g_chk
         word_ecc_a: assert property (@(posedge clk_i) disable iff (rst_i)
            upd[h] |=> !(^store[h]) && store[h][ECC_MSB:ECC_LSB] == ham_par(store[h][DATA_W-1:0]))
            else $error("check field inconsistent after update");

         // a write goes through the encoder, so a bad word comes out clean
         word_scrub_a: assert property (@(posedge clk_i) disable iff (rst_i)
            upd[h] |=> !sec[h] && !ded[h])
            else $error("update did not scrub the word");
      end
   endgenerate

endmodule

// ===== test/receiver_one_calibration_regs_bench.sv
`timescale 1ns/10ps
module receiver_one_calibration_regs_bench;
   import calib_pkg::*;

   // ==========================================================
   // stimulus and observed signals
   logic              clk_i;
   logic              rst_i;
   logic [IDX_W+1:0]  adr_i;
   logic [31:0]       dat_i;
   logic [31:0]       dat_o;
   logic              we_i;
   logic [3:0]        sel_i;
   logic              cyc_i;
   logic              stb_i;
   logic              ack_o;
   logic              fsm_err_i;
   logic              rx_short_i;
   logic              irq_o;
   logic [TRIM_W-1:0] amp_trim;
   logic [OFF_W-1:0]  off_trim;
   logic              bist_en;
   logic              diag_entry;
   int                num_errors = 0;
   int                tests_run  = 0;
   logic [10:0]       diag_vals [6] = '{11'h000, 11'h400, 11'h200, 11'h100, 11'h085, 11'h07f};
   logic [6:0]        gain_vals [4] = '{7'h00, 7'h01, 7'h40, 7'h7f};
   logic [7:0]        exp_off;
   logic [3:0]        bsel = 4'hf;
   // codeword positions of data bits d0..d10, powers of two are parity
   localparam int     POS [11] = '{3, 5, 6, 7, 9, 10, 11, 12, 13, 14, 15};

   calib_regs u_dut (
      .clk_i                (clk_i),
      .rst_i                (rst_i),
      .adr_i                (adr_i),
      .dat_i                (dat_i),
      .dat_o                (dat_o),
      .we_i                 (we_i),
      .sel_i                (sel_i),
      .cyc_i                (cyc_i),
      .stb_i                (stb_i),
      .ack_o                (ack_o),
      .fsm_err_i            (fsm_err_i),
      .rx_short_i           (rx_short_i),
      .irq_o                (irq_o),
      .rx1_amplitude_trim_o (amp_trim),
      .rx1_offset_trim_o    (off_trim),
      .bist_enable_o        (bist_en),
      .diag_entry_o         (diag_entry)
   );

   // ==========================================================
   // helpers
   function automatic logic [31:0] enc(input logic [10:0] d);
      logic [3:0] p;
      p = 4'h0;
      for (int k = 0; k < 11; k++) begin
         if (d[k]) p = p ^ POS[k][3:0];
      end
      return {16'h0000, p, ^{p, d}, d};
   endfunction

   task check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task give_verdict;
      $display("errors %0d, checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // one classic cycle; the leading edge wait leaves an idle cycle between requests
   task wb(input logic [IDX_W-1:0] idx, input logic w, input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= {idx, 2'b00};
      dat_i <= d;
      sel_i <= bsel;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 16);
      if (ack_o !== 1'b1) begin
         num_errors++;
         give_verdict();
      end else begin
         q = dat_o;
         cyc_i <= 1'b0;
         stb_i <= 1'b0;
         we_i  <= 1'b0;
      end
   endtask

   task wr(input logic [IDX_W-1:0] idx, input logic [31:0] d);
      logic [31:0] q;
      wb(idx, 1'b1, d, q);
   endtask

   task rd_chk(input logic [IDX_W-1:0] idx, input logic [31:0] e);
      logic [31:0] q;
      wb(idx, 1'b0, 32'h0000_0000, q);
      check(q, e);
   endtask

   // outputs trail the shadow store by one cycle
   task settle;
      repeat (3) @(posedge clk_i);
   endtask

   task pulse_fsm;
      @(posedge clk_i);
      fsm_err_i <= 1'b1;
      @(posedge clk_i);
      fsm_err_i <= 1'b0;
      settle();
   endtask

   // ==========================================================
   // clock and sequence
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end

   initial begin
      rst_i      = 1'b1;
      cyc_i      = 1'b0;
      stb_i      = 1'b0;
      we_i       = 1'b0;
      adr_i      = '0;
      dat_i      = 32'h0000_0000;
      sel_i      = 4'hf;
      fsm_err_i  = 1'b0;
      rx_short_i = 1'b0;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      settle();
      check({31'h0, bist_en}, 32'h0000_0001);
      rd_chk(IDX_NV_GAIN, enc(11'h000));
      rd_chk(IDX_SH_GAIN, enc(11'h000));
      rd_chk(IDX_NV_DIAG, enc(11'h000));
      rd_chk(IDX_SH_DIAG, enc(11'h000));
      rd_chk(IDX_STATUS, 32'h0000_0000);
      rd_chk(IDX_MASK, 32'h0000_0000);
      // unmapped place must swallow writes and read zero
      wr(8'h10, 32'hffff_ffff);
      rd_chk(8'h10, 32'h0000_0000);
      // check bits are regenerated, written ones there are dropped
      wr(IDX_NV_GAIN, 32'h0000_ffff);
      rd_chk(IDX_NV_GAIN, enc(11'h7ff));
      wr(IDX_SH_GAIN, 32'h0000_ffff);
      rd_chk(IDX_SH_GAIN, enc(11'h07f));
      for (int i = 0; i < 4; i++) begin
         wr(IDX_SH_GAIN, {25'h0, gain_vals[i]});
         settle();
         check({25'h0, amp_trim}, {25'h0, gain_vals[i]});
      end
      rx_short_i <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         wr(IDX_SH_DIAG, {16'hffff, 5'h1f, diag_vals[i]});
         rd_chk(IDX_SH_DIAG, enc(diag_vals[i]));
         settle();
         exp_off = {1'b0, diag_vals[i][6:0]};
         if (diag_vals[i][7]) exp_off = -exp_off;
         check({24'h0, off_trim}, {24'h0, exp_off});
         check({31'h0, bist_en}, {31'h0, ~diag_vals[i][9]});
         check({31'h0, diag_entry}, {31'h0, ~diag_vals[i][8]});
      end
      rx_short_i <= 1'b0;
      settle();
      check({31'h0, diag_entry}, 32'h0000_0000);
      // ==========================================================
      // fsm error interrupt: enabled, disabled, masked
      wr(IDX_MASK, 32'h0000_0007);
      wr(IDX_SH_DIAG, 32'h0000_0000);
      pulse_fsm();
      check({31'h0, irq_o}, 32'h0000_0001);
      rd_chk(IDX_STATUS, 32'h0000_0001);
      wr(IDX_STATUS, 32'h0000_0001);
      settle();
      check({31'h0, irq_o}, 32'h0000_0000);
      wr(IDX_SH_DIAG, 32'h0000_0400);
      pulse_fsm();
      check({31'h0, irq_o}, 32'h0000_0000);
      rd_chk(IDX_STATUS, 32'h0000_0000);
      wr(IDX_SH_DIAG, 32'h0000_0000);
      wr(IDX_MASK, 32'h0000_0000);
      pulse_fsm();
      check({31'h0, irq_o}, 32'h0000_0000);
      rd_chk(IDX_STATUS, 32'h0000_0001);
      wr(IDX_STATUS, 32'h0000_0001);
      // ==========================================================
      // load, single and double error on the shadow diag word
      wr(IDX_NV_DIAG, 32'h0000_0285);
      wr(IDX_CTRL, 32'h0000_0001);
      rd_chk(IDX_SH_DIAG, enc(11'h285));
      rd_chk(IDX_CTRL, 32'h0000_0000);
      wr(IDX_FLIP, 32'h0003_0004);
      rd_chk(IDX_SH_DIAG, enc(11'h285));
      rd_chk(IDX_STATUS, 32'h0000_0002);
      // scrub before clearing, a bad word re-sets its flag every cycle
      wr(IDX_SH_DIAG, 32'h0000_0285);
      wr(IDX_STATUS, 32'h0000_0007);
      rd_chk(IDX_STATUS, 32'h0000_0000);
      wr(IDX_MASK, 32'h0000_0004);
      wr(IDX_FLIP, 32'h0003_0003);
      settle();
      check({31'h0, irq_o}, 32'h0000_0001);
      rd_chk(IDX_STATUS, 32'h0000_0004);
      wr(IDX_SH_DIAG, 32'h0000_0285);
      wr(IDX_STATUS, 32'h0000_0007);
      rd_chk(IDX_STATUS, 32'h0000_0000);
      // byte lanes: sel[1] reaches bits 10:8 only, sel[0] bits 7:0 only
      bsel = 4'h2;
      wr(IDX_NV_DIAG, 32'h0000_04ff);
      rd_chk(IDX_NV_DIAG, enc(11'h485));
      bsel = 4'h1;
      wr(IDX_NV_DIAG, 32'h0000_0700);
      rd_chk(IDX_NV_DIAG, enc(11'h400));
      bsel = 4'hf;
      // a reset in mid-run returns words, mask and controls to their defaults
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      settle();
      check({31'h0, bist_en}, 32'h0000_0001);
      rd_chk(IDX_NV_DIAG, enc(11'h000));
      rd_chk(IDX_SH_DIAG, enc(11'h000));
      rd_chk(IDX_MASK, 32'h0000_0000);
      give_verdict();
   end

endmodule
